//--- buck_seq_if.sv
// Purpose: Carriers between the sequencer and its helper modules.
// Assumes: Single clock domain.
// Notes:   Top-level ports stay plain; these are internal only.
interface delay_if;
	logic run;
	logic done;
	modport ctl (output run, input done);
	modport tmr (input run, output done);
endinterface

interface pwr_if;
	logic enable;
	logic forced_pwm;
	logic crowbar;
	logic hs_on;
	logic ls_on;
	modport ctl (output enable, output forced_pwm, output crowbar, input hs_on, input ls_on);
	modport stg (input enable, input forced_pwm, input crowbar, output hs_on, output ls_on);
endinterface

//--- buck_seq_monitor.sv
// Purpose: Concurrent checks on the sequencer top ports.
// Assumes: One clock; delay parameters handed on from the instance.
// Notes:   Run-length counters give the timed checks their exact figures.
module buck_seq_monitor #(
	parameter int unsigned PG_DELAY_CYC  = 30,
	parameter int unsigned PG_PROP_CYC   = 10,
	parameter int unsigned FPWM_HOLD_CYC = 16
) (
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	input wire logic i_enable,
	input wire logic i_bias_below_por,
	input wire logic i_ramp_at_target,
	input wire logic i_out_in_regulation,
	input wire logic i_overvoltage_trip,
	input wire logic i_output_undervoltage_trip,
	input wire logic i_valley_current_limit,
	input wire logic i_neg_current_limit,
	input wire logic i_zero_cross,
	input wire logic i_pwm_trip,
	input wire logic o_hs_on,
	input wire logic o_ls_on,
	input wire logic o_forced_pwm,
	input wire logic o_output_valid_flag_oe,
	input wire logic o_overvoltage_latched,
	input wire logic o_undervoltage_latched
);
	logic [31:0] uv_run_r, uv_run_nxt, at_run_r, at_run_nxt, ok_run_r, ok_run_nxt;

	default clocking @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_rst_b);

	// Consecutive-cycle counts of each timed cause; far too short to wrap
	always_comb begin
		uv_run_nxt = i_output_undervoltage_trip ? uv_run_r + 32'h1 : 32'h0;
		at_run_nxt = i_ramp_at_target ? at_run_r + 32'h1 : 32'h0;
		ok_run_nxt = (i_out_in_regulation && i_enable) ? ok_run_r + 32'h1 : 32'h0;
	end
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			uv_run_r <= 32'h0;
			at_run_r <= 32'h0;
			ok_run_r <= 32'h0;
		end else begin
			uv_run_r <= uv_run_nxt;
			at_run_r <= at_run_nxt;
			ok_run_r <= ok_run_nxt;
		end
	end

	// Steps of a latched-off period and of one on-pulse
	sequence uv_held;
		o_undervoltage_latched [*3];
	endsequence
	sequence pulse_start;
		$rose(o_hs_on) && i_pwm_trip;
	endsequence
	sequence trip_stuck;
		i_pwm_trip [*6];
	endsequence

	a_pg_enable_drop: assert property (!i_enable |=> o_output_valid_flag_oe)
		else $error("valid flag kept with enable low");
	a_pg_rise_delay: assert property ($fell(o_output_valid_flag_oe)
		|-> ok_run_r >= PG_DELAY_CYC + PG_PROP_CYC) else $error("valid flag too early");
	a_fpwm_hold_time: assert property ($fell(o_forced_pwm) && i_enable
		|-> at_run_r >= FPWM_HOLD_CYC) else $error("forced PWM ended too soon");
	a_ov_pg_drop: assert property (i_overvoltage_trip |=> o_output_valid_flag_oe)
		else $error("valid flag kept on overvoltage");
	a_ov_latch_hold: assert property (o_overvoltage_latched && !i_bias_below_por
		|=> o_overvoltage_latched) else $error("overvoltage latch lost");
	a_uv_pg_drop: assert property (i_output_undervoltage_trip |=> o_output_valid_flag_oe)
		else $error("valid flag kept on undervoltage");
	a_uv_delay_count: assert property ($rose(o_undervoltage_latched)
		|-> uv_run_r >= buck_seq_pkg::UV_DELAY_CYC) else $error("undervoltage latch early");
	a_uv_latched_off: assert property (uv_held
		|-> !o_hs_on && !o_ls_on && o_output_valid_flag_oe) else $error("switching while latched");
	a_valley_no_pulse: assert property (i_valley_current_limit && !o_hs_on |=> !o_hs_on)
		else $error("on-pulse over the valley limit");
	a_one_trip_pulse: assert property (pulse_start ##1 trip_stuck |-> !$rose(o_hs_on))
		else $error("double pulse from one trip");
	a_neg_limit_off: assert property (o_ls_on && i_neg_current_limit && !i_pwm_trip
		&& !o_overvoltage_latched |=> !o_ls_on) else $error("low side kept past negative limit");
	a_skip_zero_off: assert property (o_ls_on && i_zero_cross && !o_forced_pwm
		&& !i_pwm_trip && !o_overvoltage_latched |=> !o_ls_on) else $error("low side kept at reversal");
endmodule // buck_seq_monitor

bind buck_sequencer buck_seq_monitor #(
	.PG_DELAY_CYC(PG_DELAY_CYC),
	.PG_PROP_CYC(PG_PROP_CYC),
	.FPWM_HOLD_CYC(FPWM_HOLD_CYC)
) u_buck_seq_monitor (
	.i_ref_clk, .i_rst_b, .i_enable, .i_bias_below_por, .i_ramp_at_target,
	.i_out_in_regulation, .i_overvoltage_trip, .i_output_undervoltage_trip,
	.i_valley_current_limit, .i_pwm_trip, .o_hs_on, .o_ls_on, .o_forced_pwm,
	.i_neg_current_limit, .i_zero_cross,
	.o_output_valid_flag_oe, .o_overvoltage_latched, .o_undervoltage_latched
);

//--- buck_seq_pkg.sv
// Purpose: Shared constants for the step-down converter sequencer.
// Assumes: 100 MHz reference clock.
// Notes:   Times keep their own unit; cycle counts are derived from them.
package buck_seq_pkg;

	// Reference clock
	localparam int unsigned CLK_PERIOD_NS = 10;

	// Times as specified
	localparam int unsigned FPWM_HOLD_US = 64;
	localparam int unsigned PG_DELAY_MS  = 3;
	localparam int unsigned PG_PROP_MS   = 1;
	localparam int unsigned UV_DELAY_US  = 8;

	// Least times, rounded up to whole cycles
	localparam int unsigned FPWM_HOLD_CYC =
		(FPWM_HOLD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned PG_DELAY_CYC =
		(PG_DELAY_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned PG_PROP_CYC =
		(PG_PROP_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned UV_DELAY_CYC =
		(UV_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Reset values
	localparam logic [1:0] VSEL_RST = 2'h0;
	localparam logic       PG_RST   = 1'h0;

	// Voltage-select bit that marks the lower set point
	localparam int unsigned VSEL_UPPER_POS = 1;

	// Sequencer states
	typedef enum logic [3:0] {
		SEQ_OFF   = 4'h1,
		SEQ_RAMP  = 4'h2,
		SEQ_RUN   = 4'h4,
		SEQ_LATCH = 4'h8
	} seq_state_t;

	// Power stage states
	typedef enum logic [2:0] {
		PWR_IDLE = 3'h1,
		PWR_HIGH = 3'h2,
		PWR_LOW  = 3'h4
	} pwr_state_t;

endpackage

//--- buck_sequencer.sv
// Purpose: Startup, voltage transition and protection sequencer of a buck converter.
// Assumes: Every analog decision arrives as a flag synchronous to i_ref_clk.
// Notes:   Long delays are parameters so that simulation can shorten them.
module buck_sequencer #(
	parameter int unsigned PG_DELAY_CYC  = buck_seq_pkg::PG_DELAY_CYC,
	parameter int unsigned PG_PROP_CYC   = buck_seq_pkg::PG_PROP_CYC,
	parameter int unsigned FPWM_HOLD_CYC = buck_seq_pkg::FPWM_HOLD_CYC
) (
	input  wire logic       i_ref_clk,
	input  wire logic       i_rst_b,
	input  wire logic       i_enable,
	input  wire logic [1:0] i_voltage_select,
	input  wire logic       i_bias_above_start,
	input  wire logic       i_bias_below_lockout,
	input  wire logic       i_bias_below_por,
	input  wire logic       i_ramp_at_target,
	input  wire logic       i_ramp_above_target,
	input  wire logic       i_out_in_regulation,
	input  wire logic       i_overvoltage_trip,
	input  wire logic       i_output_undervoltage_trip,
	input  wire logic       i_valley_current_limit,
	input  wire logic       i_neg_current_limit,
	input  wire logic       i_over_temp,
	input  wire logic       i_temp_cooled,
	input  wire logic       i_pwm_trip,
	input  wire logic       i_on_time_end,
	input  wire logic       i_zero_cross,
	output logic            o_ramp_charge,
	output logic            o_ramp_discharge,
	output logic            o_ramp_reset,
	output logic [1:0]      o_ramp_target,
	output logic            o_hs_on,
	output logic            o_ls_on,
	output logic            o_sw_tristate,
	output logic            o_forced_pwm,
	output logic            o_output_valid_flag_out,
	output logic            o_output_valid_flag_oe,
	output logic            o_bias_undervoltage_lockout,
	output logic            o_overvoltage_latched,
	output logic            o_undervoltage_latched,
	output logic            o_thermal_shutdown
);

	generate
		if (PG_DELAY_CYC < 1 || PG_PROP_CYC < 1 || FPWM_HOLD_CYC < 1) begin : g_bad
			$error("buck_sequencer delay counts must be at least one cycle");
		end
	endgenerate

	delay_if pg_dly ();
	delay_if pg_prop ();
	delay_if uv_dly ();
	delay_if fpwm_dly ();
	pwr_if   pwr ();

	// Delay counters, all on the reference clock
	delay_timer #(.CYCLES(PG_DELAY_CYC)) u_pg_dly (
		.i_ref_clk (i_ref_clk),
		.i_rst_b   (i_rst_b),
		.tif       (pg_dly.tmr)
	);
	delay_timer #(.CYCLES(PG_PROP_CYC)) u_pg_prop (
		.i_ref_clk (i_ref_clk),
		.i_rst_b   (i_rst_b),
		.tif       (pg_prop.tmr)
	);
	delay_timer #(.CYCLES(buck_seq_pkg::UV_DELAY_CYC)) u_uv_dly (
		.i_ref_clk (i_ref_clk),
		.i_rst_b   (i_rst_b),
		.tif       (uv_dly.tmr)
	);
	delay_timer #(.CYCLES(FPWM_HOLD_CYC)) u_fpwm_dly (
		.i_ref_clk (i_ref_clk),
		.i_rst_b   (i_rst_b),
		.tif       (fpwm_dly.tmr)
	);

	power_stage_ctl u_stage (
		.i_ref_clk              (i_ref_clk),
		.i_rst_b                (i_rst_b),
		.i_pwm_trip             (i_pwm_trip),
		.i_on_time_end          (i_on_time_end),
		.i_valley_current_limit (i_valley_current_limit),
		.i_neg_current_limit    (i_neg_current_limit),
		.i_zero_cross           (i_zero_cross),
		.pif                    (pwr.stg)
	);

	buck_seq_pkg::seq_state_t st_r;
	buck_seq_pkg::seq_state_t st_nxt;
	logic                     bias_ok_r;
	logic                     bias_ok_nxt;
	logic                     bias_undervoltage_lockout_r;
	logic                     bias_undervoltage_lockout_nxt;
	logic                     ov_r;
	logic                     ov_nxt;
	logic                     uv_r;
	logic                     uv_nxt;
	logic                     ot_r;
	logic                     ot_nxt;
	logic                     en_d_r;
	logic                     en_fall;
	logic [1:0]               vsel_r;
	logic [1:0]               vsel_nxt;
	logic                     vid_busy_r;
	logic                     vid_busy_nxt;
	logic                     fpwm_r;
	logic                     fpwm_nxt;
	logic                     pg_r;
	logic                     pg_nxt;
	logic                     can_run;
	logic                     ramping;
	logic                     vsel_change;

	assign en_fall = en_d_r && !i_enable;

	// Bias comparator with hysteresis and the lockout latch
	always_comb begin
		bias_ok_nxt = bias_ok_r;
		bias_undervoltage_lockout_nxt    = bias_undervoltage_lockout_r;
		if (i_bias_above_start) begin
			bias_ok_nxt = 1'b1;
		end else if (i_bias_below_lockout) begin
			bias_ok_nxt = 1'b0;
		end
		if (bias_ok_r && i_bias_below_lockout && !i_bias_above_start) begin
			bias_undervoltage_lockout_nxt = 1'b1;
		end else if (i_bias_below_por) begin
			bias_undervoltage_lockout_nxt = 1'b0;
		end
	end

	// Fault latches; a new trip wins over a clear in the same cycle
	always_comb begin
		ov_nxt = ov_r;
		uv_nxt = uv_r;
		ot_nxt = ot_r;
		if (i_overvoltage_trip && st_r != buck_seq_pkg::SEQ_OFF) begin
			ov_nxt = 1'b1;
		end else if (i_bias_below_por) begin
			ov_nxt = 1'b0;
		end
		if (uv_dly.done) begin
			uv_nxt = 1'b1;
		end else if (en_fall || i_bias_below_por) begin
			uv_nxt = 1'b0;
		end
		if (i_over_temp) begin
			ot_nxt = 1'b1;
		end else if (i_temp_cooled) begin
			ot_nxt = 1'b0;
		end
	end

	assign can_run = i_enable && bias_ok_r && !bias_undervoltage_lockout_r && !ot_r;

	// Undervoltage counted only while converting and not already latched
	assign uv_dly.run = i_output_undervoltage_trip && !uv_r && can_run &&
		(st_r == buck_seq_pkg::SEQ_RAMP || st_r == buck_seq_pkg::SEQ_RUN);

	// Main sequence
	always_comb begin
		st_nxt = st_r;
		unique case (st_r)
			buck_seq_pkg::SEQ_OFF: begin
				if (can_run && !uv_r && !ov_r) begin
					st_nxt = buck_seq_pkg::SEQ_RAMP;
				end
			end
			buck_seq_pkg::SEQ_RAMP: begin
				if (i_ramp_at_target) begin
					st_nxt = buck_seq_pkg::SEQ_RUN;
				end
			end
			buck_seq_pkg::SEQ_RUN: begin
				st_nxt = buck_seq_pkg::SEQ_RUN;
			end
			buck_seq_pkg::SEQ_LATCH: begin
				if (!uv_r && !ov_r) begin
					st_nxt = buck_seq_pkg::SEQ_OFF;
				end
			end
			default: begin
				st_nxt = buck_seq_pkg::SEQ_OFF;
			end
		endcase
		if (st_r != buck_seq_pkg::SEQ_OFF && st_r != buck_seq_pkg::SEQ_LATCH) begin
			if (uv_nxt || ov_nxt) begin
				st_nxt = buck_seq_pkg::SEQ_LATCH;
			end else if (!can_run) begin
				st_nxt = buck_seq_pkg::SEQ_OFF;
			end
		end
	end

	// Target capture and transition tracking
	assign vsel_change = (st_r == buck_seq_pkg::SEQ_RUN) && (i_voltage_select != vsel_r);
	always_comb begin
		vsel_nxt     = vsel_r;
		vid_busy_nxt = vid_busy_r;
		fpwm_nxt     = fpwm_r;
		if (st_r == buck_seq_pkg::SEQ_OFF) begin
			vsel_nxt     = i_voltage_select;
			vid_busy_nxt = 1'b0;
			fpwm_nxt     = 1'b0;
		end else if (vsel_change) begin
			vsel_nxt     = i_voltage_select;
			vid_busy_nxt = 1'b1;
			if (!vsel_r[buck_seq_pkg::VSEL_UPPER_POS] &&
				i_voltage_select[buck_seq_pkg::VSEL_UPPER_POS]) begin
				fpwm_nxt = 1'b1;
			end
		end else begin
			if (vid_busy_r && i_ramp_at_target) begin
				vid_busy_nxt = 1'b0;
			end
			if (fpwm_dly.done) begin
				fpwm_nxt = 1'b0;
			end
		end
		if (st_nxt != buck_seq_pkg::SEQ_RUN && st_nxt != buck_seq_pkg::SEQ_RAMP) begin
			fpwm_nxt = 1'b0;
		end
	end

	// Hold counted from the end of the ramp only
	assign fpwm_dly.run = fpwm_r && !vid_busy_r && !vsel_change;

	assign ramping = (st_r == buck_seq_pkg::SEQ_RAMP) || vid_busy_r;

	// Output-valid chain; a select ramp keeps the delay running so it cannot drop
	assign pg_dly.run = (st_r == buck_seq_pkg::SEQ_RUN) && can_run && !ov_r && !uv_r &&
		!i_output_undervoltage_trip &&
		(i_out_in_regulation || (vid_busy_r && pg_r));
	assign pg_prop.run = pg_dly.run && pg_dly.done;

	always_comb begin
		pg_nxt = pg_prop.done;
		if (!i_enable || !bias_ok_r || bias_undervoltage_lockout_r) begin
			pg_nxt = 1'b0;
		end
		if (i_overvoltage_trip || ov_r) begin
			pg_nxt = 1'b0;
		end
		if (i_output_undervoltage_trip || uv_r) begin
			pg_nxt = 1'b0;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st_r       <= buck_seq_pkg::SEQ_OFF;
			bias_ok_r  <= 1'b0;
			bias_undervoltage_lockout_r     <= 1'b0;
			ov_r       <= 1'b0;
			uv_r       <= 1'b0;
			ot_r       <= 1'b0;
			en_d_r     <= 1'b0;
			vsel_r     <= buck_seq_pkg::VSEL_RST;
			vid_busy_r <= 1'b0;
			fpwm_r     <= 1'b0;
			pg_r       <= buck_seq_pkg::PG_RST;
		end else begin
			st_r       <= st_nxt;
			bias_ok_r  <= bias_ok_nxt;
			bias_undervoltage_lockout_r     <= bias_undervoltage_lockout_nxt;
			ov_r       <= ov_nxt;
			uv_r       <= uv_nxt;
			ot_r       <= ot_nxt;
			en_d_r     <= i_enable;
			vsel_r     <= vsel_nxt;
			vid_busy_r <= vid_busy_nxt;
			fpwm_r     <= fpwm_nxt;
			pg_r       <= pg_nxt;
		end
	end

	// Power stage steering; overvoltage holds the low side on, outside bias lockout, to pull the output down
	assign pwr.enable     = (st_r == buck_seq_pkg::SEQ_RAMP) || (st_r == buck_seq_pkg::SEQ_RUN);
	assign pwr.forced_pwm = fpwm_r;
	assign pwr.crowbar    = ov_r && !bias_undervoltage_lockout_r;

	// Ramp source; direction from the ramp comparator, reset while off
	assign o_ramp_charge    = ramping && !i_ramp_at_target && !i_ramp_above_target;
	assign o_ramp_discharge = ramping && !i_ramp_at_target && i_ramp_above_target;
	assign o_ramp_reset     = (st_r == buck_seq_pkg::SEQ_OFF);
	assign o_ramp_target    = vsel_r;

	assign o_hs_on       = pwr.hs_on;
	assign o_ls_on       = pwr.ls_on;
	assign o_sw_tristate = !pwr.hs_on && !pwr.ls_on;
	assign o_forced_pwm  = fpwm_r;

	// Open-drain flag: pulled low whenever not valid
	assign o_output_valid_flag_out = 1'b0;
	assign o_output_valid_flag_oe  = !pg_r;

	assign o_bias_undervoltage_lockout = bias_undervoltage_lockout_r;
	assign o_overvoltage_latched       = ov_r;
	assign o_undervoltage_latched      = uv_r;
	assign o_thermal_shutdown          = ot_r;

endmodule // buck_sequencer

//--- buck_sequencing_protection_bench.sv
// Purpose: Self-checking bench for the converter sequencer.
// Assumes: Short delay parameters; comparator flags driven as levels.
// Notes:   Power stage flags chatter at random while the scenarios run.
module buck_sequencing_protection_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int unsigned PGD = 30;
	localparam int unsigned PGP = 10;
	localparam int unsigned FPH = 16;
	logic       i_ref_clk, i_rst_b, i_enable, i_bias_above_start, i_bias_below_lockout;
	logic       i_bias_below_por, i_ramp_at_target, i_ramp_above_target, i_out_in_regulation;
	logic       i_overvoltage_trip, i_output_undervoltage_trip, i_valley_current_limit;
	logic       i_neg_current_limit, i_over_temp, i_temp_cooled, i_pwm_trip, i_on_time_end;
	logic       i_zero_cross, o_ramp_charge, o_ramp_discharge, o_ramp_reset, o_hs_on, o_ls_on;
	logic       o_sw_tristate, o_forced_pwm, o_output_valid_flag_oe, o_bias_undervoltage_lockout;
	logic       o_overvoltage_latched, o_undervoltage_latched, o_thermal_shutdown;
	logic       slow, en_cmd, rnd_on, v_force, t_force, prev, o_output_valid_flag_out;
	logic [1:0] i_voltage_select, vsel_cmd, o_ramp_target;
	int         errors, cmp_count, seed, n, k;

	buck_sequencer #(.PG_DELAY_CYC(PGD), .PG_PROP_CYC(PGP), .FPWM_HOLD_CYC(FPH)) u_buck_sequencer (
		.i_ref_clk, .i_rst_b, .i_enable, .i_voltage_select, .i_bias_above_start,
		.i_bias_below_lockout, .i_bias_below_por, .i_ramp_at_target, .i_ramp_above_target,
		.i_out_in_regulation, .i_overvoltage_trip, .i_output_undervoltage_trip,
		.i_valley_current_limit, .i_neg_current_limit, .i_over_temp, .i_temp_cooled,
		.i_pwm_trip, .i_on_time_end, .i_zero_cross, .o_ramp_charge, .o_ramp_discharge,
		.o_ramp_reset, .o_ramp_target, .o_hs_on, .o_ls_on, .o_sw_tristate, .o_forced_pwm,
		.o_output_valid_flag_out, .o_output_valid_flag_oe, .o_bias_undervoltage_lockout,
		.o_overvoltage_latched, .o_undervoltage_latched, .o_thermal_shutdown);

	sys_seq_model u_sys_seq_model (.i_clk(i_ref_clk), .i_rst_b, .i_slow(slow),
		.i_en_cmd(en_cmd), .i_vsel_cmd(vsel_cmd), .o_enable(i_enable),
		.o_voltage_select(i_voltage_select));

	// Clock at 100 MHz
	always #5 i_ref_clk = ~i_ref_clk;

	function automatic logic rbit(input int m);
		return ($random(seed) & m) == 0;
	endfunction
	function automatic logic fpwm_exp(input logic [1:0] a, input logic [1:0] b);
		return !a[1] && b[1];
	endfunction
	function automatic logic uv_exp(input int held);
		return held >= int'(buck_seq_pkg::UV_DELAY_CYC);
	endfunction

	// Comparator chatter; limits kept rare so pulses still happen
	always @(posedge i_ref_clk) begin
		if (rnd_on) begin
			i_pwm_trip             <= t_force | rbit(1);
			i_on_time_end          <= rbit(1);
			i_zero_cross           <= rbit(1);
			i_valley_current_limit <= v_force | rbit(7);
			i_neg_current_limit    <= rbit(7);
		end
	end

	task automatic chk(input logic exp, input logic got);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask
	task automatic cyc(input int c);
		repeat (c) @(negedge i_ref_clk);
	endtask
	task automatic complete_run();
		if (errors == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Soft start, then regulation; valid flag only after both delays
	task automatic bring_up();
		@(posedge i_ref_clk) en_cmd <= 1'h1;
		i_ramp_at_target <= 1'h0;
		i_out_in_regulation <= 1'h0;
		for (n = 0; n < 40 && o_ramp_charge !== 1'b1; n++) cyc(1);
		chk(1'h1, o_ramp_charge);
		cyc(20);
		chk(1'h1, o_output_valid_flag_oe);
		@(posedge i_ref_clk) i_ramp_at_target <= 1'h1;
		i_out_in_regulation <= 1'h1;
		for (n = 0; n < 200 && o_output_valid_flag_oe !== 1'b0; n++) cyc(1);
		chk(1'h1, n >= PGD + PGP);
		chk(1'h1, n <= PGD + PGP + 6);
	endtask

	// Main sequence of scenarios
	initial begin
		{i_ref_clk, i_rst_b, i_bias_above_start, i_bias_below_lockout, i_bias_below_por} = 5'h0;
		{i_ramp_at_target, i_ramp_above_target, i_out_in_regulation, i_overvoltage_trip} = 4'h0;
		{i_output_undervoltage_trip, i_valley_current_limit, i_neg_current_limit} = 3'h0;
		{i_over_temp, i_temp_cooled, i_pwm_trip, i_on_time_end, i_zero_cross} = 5'h0;
		{slow, en_cmd, rnd_on, v_force, t_force, prev} = 6'h0;
		vsel_cmd = 2'h0;
		seed = 31;
		errors = 0;
		cmp_count = 0;
		repeat (16) @(posedge i_ref_clk);
		i_rst_b <= 1'h1;
		cyc(2);
		chk(1'h1, o_sw_tristate);
		@(posedge i_ref_clk) en_cmd <= 1'h1;
		cyc(20);
		chk(1'h1, o_ramp_reset);
		@(posedge i_ref_clk) i_bias_above_start <= 1'h1;
		rnd_on <= 1'h1;
		bring_up();
		// Valley limit held: no on-pulse may start
		@(posedge i_ref_clk) v_force <= 1'h1;
		cyc(12);
		k = 0;
		for (n = 0; n < 30; n++) begin
			cyc(1);
			k += int'(o_hs_on);
		end
		chk(1'h1, k == 0);
		// Trip stuck high: one pulse at most
		@(posedge i_ref_clk) v_force <= 1'h0;
		t_force <= 1'h1;
		k = 0;
		for (n = 0; n < 30; n++) begin
			cyc(1);
			k += int'(o_hs_on && !prev);
			prev = o_hs_on;
		end
		chk(1'h1, k <= 1);
		// Step down in voltage: forced PWM, flag kept valid, then the hold
		@(posedge i_ref_clk) t_force <= 1'h0;
		vsel_cmd <= 2'h2;
		i_ramp_at_target <= 1'h0;
		i_ramp_above_target <= 1'h1;
		// Output leaves regulation only once the new select reaches the pin
		repeat (2) @(posedge i_ref_clk);
		i_out_in_regulation <= 1'h0;
		cyc(10);
		chk(fpwm_exp(2'h0, 2'h2), o_forced_pwm);
		chk(1'h1, o_ramp_target == 2'h2);
		chk(1'h1, o_ramp_discharge);
		chk(1'h0, o_output_valid_flag_oe);
		@(posedge i_ref_clk) i_ramp_at_target <= 1'h1;
		i_ramp_above_target <= 1'h0;
		i_out_in_regulation <= 1'h1;
		for (n = 0; n < 100 && o_forced_pwm !== 1'b0; n++) cyc(1);
		chk(1'h1, n >= FPH && n <= FPH + 4);
		@(posedge i_ref_clk) vsel_cmd <= 2'h0;
		cyc(10);
		chk(fpwm_exp(2'h2, 2'h0), o_forced_pwm);
		// Late enable drop through the slow host
		@(posedge i_ref_clk) slow <= 1'h1;
		en_cmd <= 1'h0;
		for (n = 0; n < 20 && i_enable !== 1'b0; n++) cyc(1);
		cyc(1);
		chk(1'h1, o_output_valid_flag_oe);
		chk(1'h0, o_output_valid_flag_out);
		bring_up();
		// Output collapse: flag first, latch after the delay, held after recovery, cleared by the enable drop
		@(posedge i_ref_clk) i_output_undervoltage_trip <= 1'h1;
		cyc(5);
		chk(1'h1, o_output_valid_flag_oe);
		cyc(785);
		chk(uv_exp(790), o_undervoltage_latched);
		cyc(20);
		chk(uv_exp(810), o_undervoltage_latched);
		chk(1'h0, o_hs_on | o_ls_on);
		@(posedge i_ref_clk) i_output_undervoltage_trip <= 1'h0;
		cyc(20);
		chk(1'h1, o_undervoltage_latched);
		@(posedge i_ref_clk) en_cmd <= 1'h0;
		cyc(10);
		chk(1'h0, o_undervoltage_latched);
		bring_up();
		// Overvoltage outlives an enable cycle; only power-on reset clears it
		@(posedge i_ref_clk) i_overvoltage_trip <= 1'h1;
		@(posedge i_ref_clk) i_overvoltage_trip <= 1'h0;
		cyc(2);
		chk(1'h1, o_overvoltage_latched);
		chk(1'h1, o_output_valid_flag_oe);
		@(posedge i_ref_clk) en_cmd <= 1'h0;
		cyc(10);
		chk(1'h1, o_overvoltage_latched);
		@(posedge i_ref_clk) i_bias_below_por <= 1'h1;
		@(posedge i_ref_clk) i_bias_below_por <= 1'h0;
		cyc(2);
		chk(1'h0, o_overvoltage_latched);
		bring_up();
		// Overheat stops the converter; cooling restarts it by soft start
		@(posedge i_ref_clk) i_over_temp <= 1'h1;
		cyc(4);
		chk(1'h1, o_thermal_shutdown);
		chk(1'h1, o_output_valid_flag_oe);
		@(posedge i_ref_clk) i_over_temp <= 1'h0;
		i_temp_cooled <= 1'h1;
		i_ramp_at_target <= 1'h0;
		cyc(5);
		chk(1'h0, o_thermal_shutdown);
		chk(1'h1, o_ramp_charge);
		// Bias lockout holds until power-on reset
		@(posedge i_ref_clk) i_bias_below_lockout <= 1'h1;
		i_bias_above_start <= 1'h0;
		i_temp_cooled <= 1'h0;
		cyc(4);
		chk(1'h1, o_bias_undervoltage_lockout);
		chk(1'h1, o_sw_tristate);
		@(posedge i_ref_clk) i_bias_below_lockout <= 1'h0;
		cyc(10);
		chk(1'h1, o_bias_undervoltage_lockout);
		@(posedge i_ref_clk) i_bias_below_por <= 1'h1;
		@(posedge i_ref_clk) i_bias_below_por <= 1'h0;
		cyc(5);
		chk(1'h0, o_bias_undervoltage_lockout);
		complete_run();
	end

	// Watchdog: the sequence needs some 1400 cycles, allow about twenty times that
	initial begin
		#300000;
		errors++;
		complete_run();
	end
endmodule // buck_sequencing_protection_bench

//--- delay_timer.sv
// Purpose: Counts clock cycles while run is high; done once the count is reached.
// Assumes: run drops to restart; done holds while run stays high.
// Notes:   Counter saturates, so a long run never wraps back to not-done.
module delay_timer #(
	parameter int unsigned CYCLES = 8
) (
	input  wire logic i_ref_clk,
	input  wire logic i_rst_b,
	delay_if.tmr      tif
);

	localparam int unsigned CW = $clog2(CYCLES + 1);

	generate
		if (CYCLES < 1) begin : g_bad
			$error("delay_timer needs at least one cycle");
		end
	endgenerate

	logic [CW-1:0] cnt_r;
	logic [CW-1:0] cnt_nxt;
	logic          done_r;
	logic          done_nxt;

	// Count while running, clear otherwise
	always_comb begin
		cnt_nxt  = '0;
		done_nxt = 1'b0;
		if (tif.run) begin
			if (cnt_r == CW'(CYCLES - 1)) begin
				done_nxt = 1'b1;
				cnt_nxt  = cnt_r;
			end else begin
				cnt_nxt = cnt_r + CW'(1);
			end
			if (done_r) begin
				done_nxt = 1'b1;
			end
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cnt_r  <= '0;
			done_r <= 1'b0;
		end else begin
			cnt_r  <= cnt_nxt;
			done_r <= done_nxt;
		end
	end

	assign tif.done = done_r;

endmodule // delay_timer

//--- power_stage_ctl.sv
// Purpose: On-pulse latch and low-side control for the power switches.
// Assumes: Comparator flags are synchronous; on-time end comes from the analog timer.
// Notes:   High and low side are never on together.
module power_stage_ctl (
	input  wire logic i_ref_clk,
	input  wire logic i_rst_b,
	input  wire logic i_pwm_trip,
	input  wire logic i_on_time_end,
	input  wire logic i_valley_current_limit,
	input  wire logic i_neg_current_limit,
	input  wire logic i_zero_cross,
	pwr_if.stg        pif
);

	buck_seq_pkg::pwr_state_t st_r;
	buck_seq_pkg::pwr_state_t st_nxt;
	logic                     armed_r;
	logic                     armed_nxt;
	logic                     hs_r;
	logic                     hs_nxt;
	logic                     ls_r;
	logic                     ls_nxt;
	logic                     fire;

	// A pulse needs a fresh trip and a valley current under the limit
	assign fire = pif.enable && i_pwm_trip && armed_r && !i_valley_current_limit;

	always_comb begin
		st_nxt    = st_r;
		armed_nxt = armed_r;
		if (!i_pwm_trip) begin
			armed_nxt = 1'b1;
		end
		unique case (st_r)
			buck_seq_pkg::PWR_IDLE: begin
				if (fire) begin
					st_nxt = buck_seq_pkg::PWR_HIGH;
				end
			end
			buck_seq_pkg::PWR_HIGH: begin
				armed_nxt = 1'b0;
				if (i_on_time_end) begin
					st_nxt = buck_seq_pkg::PWR_LOW;
				end
			end
			buck_seq_pkg::PWR_LOW: begin
				if (fire) begin
					st_nxt = buck_seq_pkg::PWR_HIGH;
				end else if (i_neg_current_limit) begin
					st_nxt = buck_seq_pkg::PWR_IDLE;
				end else if (!pif.forced_pwm && i_zero_cross) begin
					st_nxt = buck_seq_pkg::PWR_IDLE;
				end
			end
			default: begin
				st_nxt = buck_seq_pkg::PWR_IDLE;
			end
		endcase
		if (!pif.enable || pif.crowbar) begin
			st_nxt = buck_seq_pkg::PWR_IDLE;
		end
		hs_nxt = (st_nxt == buck_seq_pkg::PWR_HIGH);
		ls_nxt = (st_nxt == buck_seq_pkg::PWR_LOW) || pif.crowbar;
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st_r    <= buck_seq_pkg::PWR_IDLE;
			armed_r <= 1'b0;
			hs_r    <= 1'b0;
			ls_r    <= 1'b0;
		end else begin
			st_r    <= st_nxt;
			armed_r <= armed_nxt;
			hs_r    <= hs_nxt;
			ls_r    <= ls_nxt;
		end
	end

	assign pif.hs_on = hs_r;
	assign pif.ls_on = ls_r;

endmodule // power_stage_ctl

//--- sys_seq_model.sv
// Purpose: Stand-in for the system sequencer on the enable and select pins.
// Assumes: The bench hands it commands as levels.
// Notes:   Slow mode applies a command five cycles late, as a lazy host would.
module sys_seq_model (
	input  wire logic       i_clk,
	input  wire logic       i_rst_b,
	input  wire logic       i_slow,
	input  wire logic       i_en_cmd,
	input  wire logic [1:0] i_vsel_cmd,
	output logic            o_enable,
	output logic [1:0]      o_voltage_select
);
	logic [2:0] lag_r;

	// Pins follow the command at once or after a short lag
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			lag_r            <= 3'h0;
			o_enable         <= 1'h0;
			o_voltage_select <= 2'h0;
		end else if ({i_en_cmd, i_vsel_cmd} == {o_enable, o_voltage_select}) begin
			lag_r <= 3'h0;
		end else if (!i_slow || lag_r == 3'h4) begin
			o_enable         <= i_en_cmd;
			o_voltage_select <= i_vsel_cmd;
		end else begin
			lag_r <= lag_r + 3'h1;
		end
	end
endmodule // sys_seq_model
